// >>> hw/dlbu_cfg.svh
// constants for the data line buffer unit
// Functional notes
// - buffers hold 128-bit lines of four words
// - only data window accesses use the buffers
// - fetches, TCM and NVM bypass the buffers
// - each buffer tagged modified, write, shared, invalid
// - modified buffer written back before any reuse
// - write buffer collects bytes, holds no read data
// - read of write buffer fetches, merges, becomes modified
// - fully written write buffer becomes modified directly
// - write to shared buffer makes it modified
// - read miss fills a shared buffer
// - invalidated shared buffer becomes invalid, no write-back
// - write miss allocates a write buffer
// - allocation takes an invalid buffer first
// - else oldest buffer, shared preferred, freed first
// - dirty buffers flushed early, modified become shared
// - level 0 keeps at most two dirty buffers
// - level 1 allows three dirty buffers
// - per-buffer enable, disabled never allocated
// - no per-address buffering choice exists
// - recency counter cleared on use, else incremented until it saturates
// - flush then invalidate empties every buffer
`ifndef DLBU_CFG_SVH
`define DLBU_CFG_SVH
`define DLBU_WIN_LO 32'h10060000
`define DLBU_WIN_HI 32'h01FFFFFF
`define DLBU_NBUF 4
`define DLBU_ADR_CTRL 4'h0
`define DLBU_ADR_STAT 4'h4
`define DLBU_CTRL_LVL 4
`define DLBU_CTRL_FLUSH 8
`define DLBU_CTRL_INVAL 9
`define DLBU_STAT_FPEND 16
`define DLBU_STAT_IPEND 17
`define DLBU_EN_RST 4'hF
`define DLBU_LVL_RST 1'b0
`define DLBU_LIMIT0 3'h2
`define DLBU_LIMIT1 3'h3
`endif

// >>> hw/dlbu_pkg.sv
// types for the data line buffer unit
package dlbu_pkg;
  typedef enum logic [1:0] {
    DLBU_INV = 2'h0,
    DLBU_SHR = 2'h1,
    DLBU_WRT = 2'h2,
    DLBU_MOD = 2'h3
  } dlbu_line_type;
  typedef enum logic [2:0] {
    DLBU_IDLE = 3'h0,
    DLBU_AR = 3'h1,
    DLBU_R = 3'h2,
    DLBU_WB = 3'h3,
    DLBU_B = 3'h4
  } dlbu_fsm_type;
endpackage : dlbu_pkg

// >>> hw/dlbu_top.sv
// data line buffer unit: line buffers, allocation, flush and register slave
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`include "dlbu_cfg.svh"
module dlbu_top #(
  parameter int NBUF = `DLBU_NBUF,
  parameter int LRUW = 2,
  parameter logic [31:0] WIN_LO = `DLBU_WIN_LO,
  parameter logic [31:0] WIN_HI = `DLBU_WIN_HI
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cpu_req_i,
  input wire logic cpu_fetch_i,
  input wire logic cpu_we_i,
  input wire logic [31:0] cpu_addr_i,
  input wire logic [3:0] cpu_be_i,
  input wire logic [31:0] cpu_wdata_i,
  output logic cpu_ack_o,
  output logic [31:0] cpu_rdata_o,
  output logic axi_arvalid_o,
  output logic [31:0] axi_araddr_o,
  input wire logic axi_arready_i,
  input wire logic axi_rvalid_i,
  input wire logic [127:0] axi_rdata_i,
  output logic axi_rready_o,
  output logic axi_awvalid_o,
  output logic [31:0] axi_awaddr_o,
  input wire logic axi_awready_i,
  output logic axi_wvalid_o,
  output logic [127:0] axi_wdata_o,
  output logic [15:0] axi_wstrb_o,
  input wire logic axi_wready_i,
  input wire logic axi_bvalid_i,
  output logic axi_bready_o
);
  localparam int IW = (NBUF > 1) ? $clog2(NBUF) : 1;
  localparam logic [LRUW-1:0] LRU_MAX = '1;

  if (NBUF < 1 || NBUF > 4 || LRUW < 1) begin : g_chk
    $error("dlbu_top: NBUF must be 1 to 4 and LRUW at least 1");
  end

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  logic [3:0] en_q, en_d;
  logic lvl_q, lvl_d, fpend_q, fpend_d, ipend_q, ipend_d;
  logic wb_ack_q, wb_ack_d;
  logic [31:0] wb_dat_q, wb_dat_d;
  logic any_dirty, inval_go;
  dlbu_pkg::dlbu_line_type st_q [NBUF];
  dlbu_pkg::dlbu_line_type st_d [NBUF];

  // decode, command bits and status read; a new command wins over completion
  always_comb begin
    en_d = en_q;
    lvl_d = lvl_q;
    fpend_d = fpend_q && any_dirty;
    ipend_d = ipend_q && !inval_go;
    wb_ack_d = wb_cyc_i && wb_stb_i && !wb_ack_q;
    wb_dat_d = 32'h0;
    if (wb_ack_d && wb_we_i && wb_adr_i == `DLBU_ADR_CTRL) begin
      if (wb_sel_i[0]) begin
        en_d = wb_dat_i[3:0];
        lvl_d = wb_dat_i[`DLBU_CTRL_LVL];
      end
      if (wb_sel_i[1] && wb_dat_i[`DLBU_CTRL_FLUSH]) fpend_d = 1'b1;
      if (wb_sel_i[1] && wb_dat_i[`DLBU_CTRL_INVAL]) ipend_d = 1'b1;
    end
    if (wb_ack_d && !wb_we_i && wb_adr_i == `DLBU_ADR_CTRL) begin
      wb_dat_d[3:0] = en_q;
      wb_dat_d[`DLBU_CTRL_LVL] = lvl_q;
    end
    if (wb_ack_d && !wb_we_i && wb_adr_i == `DLBU_ADR_STAT) begin
      for (int i = 0; i < NBUF; i++) wb_dat_d[2*i +: 2] = st_q[i];
      wb_dat_d[`DLBU_STAT_FPEND] = fpend_q;
      wb_dat_d[`DLBU_STAT_IPEND] = ipend_q;
    end
  end

  // register slave flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= `DLBU_EN_RST;
      lvl_q <= `DLBU_LVL_RST;
      fpend_q <= 1'b0;
      ipend_q <= 1'b0;
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0;
    end else begin
      en_q <= en_d;
      lvl_q <= lvl_d;
      fpend_q <= fpend_d;
      ipend_q <= ipend_d;
      wb_ack_q <= wb_ack_d;
      wb_dat_q <= wb_dat_d;
    end
  end
  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

  // ----------------------------------------------------------------
  // line buffers and controller
  // ----------------------------------------------------------------
  logic [27:0] tag_q [NBUF];
  logic [27:0] tag_d [NBUF];
  logic [127:0] dat_q [NBUF];
  logic [127:0] dat_d [NBUF];
  logic [15:0] ben_q [NBUF];
  logic [15:0] ben_d [NBUF];
  logic [LRUW-1:0] lru_q [NBUF];
  logic [LRUW-1:0] lru_d [NBUF];
  dlbu_pkg::dlbu_fsm_type fsm_q, fsm_d;
  logic [IW-1:0] idx_q, idx_d, hit_idx, vic_idx, old_idx;
  logic byp_q, byp_d, hit, have_en, bypass;
  logic [2:0] dirty_cnt;
  logic cack_q, cack_d, arv_q, arv_d, rrdy_q, rrdy_d;
  logic awv_q, awv_d, wv_q, wv_d, brdy_q, brdy_d;
  logic [31:0] crd_q, crd_d, ara_q, ara_d, awa_q, awa_d;
  logic [127:0] wd_q, wd_d, line_m;
  logic [15:0] ws_q, ws_d;
  logic [27:0] line_a;
  logic [1:0] wsel;
  logic evt, do_wr, flush_due;

  assign line_a = cpu_addr_i[31:4];
  assign wsel = cpu_addr_i[3:2];
  // too many dirty lines for the selected level
  assign flush_due = dirty_cnt > (lvl_q ? `DLBU_LIMIT1 : `DLBU_LIMIT0);

  // lookup, victim choice and dirty count
  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    have_en = 1'b0;
    vic_idx = '0;
    old_idx = '0;
    any_dirty = 1'b0;
    dirty_cnt = 3'h0;
    for (int i = 0; i < NBUF; i++) begin
      if (st_q[i] != dlbu_pkg::DLBU_INV && tag_q[i] == line_a) begin
        hit = 1'b1;
        hit_idx = IW'(i);
      end
      if (st_q[i] == dlbu_pkg::DLBU_WRT || st_q[i] == dlbu_pkg::DLBU_MOD) begin
        if (!any_dirty || lru_q[i] > lru_q[old_idx]) old_idx = IW'(i);
        any_dirty = 1'b1;
        dirty_cnt = dirty_cnt + 3'h1;
      end
    end
    // rank: invalid first, then shared, then anything, older wins
    for (int i = 0; i < NBUF; i++) begin
      if (en_q[i]) begin
        if (!have_en) vic_idx = IW'(i);
        else if (st_q[vic_idx] == dlbu_pkg::DLBU_INV) vic_idx = vic_idx;
        else if (st_q[i] == dlbu_pkg::DLBU_INV) vic_idx = IW'(i);
        else if (st_q[i] == dlbu_pkg::DLBU_SHR && st_q[vic_idx] != dlbu_pkg::DLBU_SHR)
          vic_idx = IW'(i);
        else if ((st_q[i] == dlbu_pkg::DLBU_SHR) == (st_q[vic_idx] == dlbu_pkg::DLBU_SHR)
                 && lru_q[i] > lru_q[vic_idx]) vic_idx = IW'(i);
        have_en = 1'b1;
      end
    end
    // fetch, window and buffer enables decide; there is no per-range setting
    bypass = cpu_fetch_i || cpu_addr_i < WIN_LO || cpu_addr_i > WIN_HI || !have_en;
  end

  // controller next state
  always_comb begin
    st_d = st_q;
    tag_d = tag_q;
    dat_d = dat_q;
    ben_d = ben_q;
    lru_d = lru_q;
    fsm_d = fsm_q;
    idx_d = idx_q;
    byp_d = byp_q;
    cack_d = 1'b0;
    crd_d = crd_q;
    arv_d = arv_q;
    ara_d = ara_q;
    rrdy_d = rrdy_q;
    awv_d = awv_q;
    awa_d = awa_q;
    wv_d = wv_q;
    wd_d = wd_q;
    ws_d = ws_q;
    brdy_d = brdy_q;
    evt = 1'b0;
    do_wr = 1'b0;
    inval_go = 1'b0;
    line_m = axi_rdata_i;
    case (fsm_q)
      dlbu_pkg::DLBU_IDLE: begin
        if (cpu_req_i && !cack_q) begin
          byp_d = bypass;
          if (bypass && cpu_we_i) begin
            awv_d = 1'b1;
            wv_d = 1'b1;
            awa_d = {line_a, 4'h0};
            wd_d = {4{cpu_wdata_i}};
            ws_d = 16'(cpu_be_i) << {wsel, 2'h0};
            fsm_d = dlbu_pkg::DLBU_WB;
          end else if (bypass || (hit && !cpu_we_i && st_q[hit_idx] == dlbu_pkg::DLBU_WRT)) begin
            idx_d = hit_idx;
            arv_d = 1'b1;
            ara_d = {line_a, 4'h0};
            fsm_d = dlbu_pkg::DLBU_AR;
          end else if (hit) begin
            idx_d = hit_idx;
            evt = 1'b1;
            cack_d = 1'b1;
            crd_d = dat_q[hit_idx][{wsel, 5'h0} +: 32];
            if (cpu_we_i) begin
              do_wr = 1'b1;
              if (st_q[hit_idx] == dlbu_pkg::DLBU_SHR) st_d[hit_idx] = dlbu_pkg::DLBU_MOD;
            end
          end else if (st_q[vic_idx] == dlbu_pkg::DLBU_MOD ||
                       st_q[vic_idx] == dlbu_pkg::DLBU_WRT) begin
            idx_d = vic_idx;
            byp_d = 1'b0;
            awv_d = 1'b1;
            wv_d = 1'b1;
            awa_d = {tag_q[vic_idx], 4'h0};
            wd_d = dat_q[vic_idx];
            ws_d = ben_q[vic_idx];
            fsm_d = dlbu_pkg::DLBU_WB;
          end else begin
            idx_d = vic_idx;
            evt = 1'b1;
            tag_d[vic_idx] = line_a;
            ben_d[vic_idx] = 16'h0;
            if (cpu_we_i) begin
              st_d[vic_idx] = dlbu_pkg::DLBU_WRT;
              do_wr = 1'b1;
              cack_d = 1'b1;
            end else begin
              st_d[vic_idx] = dlbu_pkg::DLBU_INV;
              arv_d = 1'b1;
              ara_d = {line_a, 4'h0};
              fsm_d = dlbu_pkg::DLBU_AR;
            end
          end
        end else if ((fpend_q && any_dirty) || flush_due) begin
          idx_d = old_idx;
          byp_d = 1'b0;
          awv_d = 1'b1;
          wv_d = 1'b1;
          awa_d = {tag_q[old_idx], 4'h0};
          wd_d = dat_q[old_idx];
          ws_d = ben_q[old_idx];
          fsm_d = dlbu_pkg::DLBU_WB;
        end else if (ipend_q && !fpend_q) begin
          inval_go = 1'b1;
          for (int i = 0; i < NBUF; i++)
            if (st_q[i] == dlbu_pkg::DLBU_SHR) st_d[i] = dlbu_pkg::DLBU_INV;
        end
      end
      dlbu_pkg::DLBU_AR: begin
        if (axi_arready_i) begin
          arv_d = 1'b0;
          rrdy_d = 1'b1;
          fsm_d = dlbu_pkg::DLBU_R;
        end
      end
      dlbu_pkg::DLBU_R: begin
        if (axi_rvalid_i) begin
          rrdy_d = 1'b0;
          fsm_d = dlbu_pkg::DLBU_IDLE;
          cack_d = 1'b1;
          if (!byp_q) begin
            evt = 1'b1;
            if (st_q[idx_q] == dlbu_pkg::DLBU_WRT) begin
              for (int k = 0; k < 16; k++)
                if (ben_q[idx_q][k]) line_m[8*k +: 8] = dat_q[idx_q][8*k +: 8];
              st_d[idx_q] = dlbu_pkg::DLBU_MOD;
            end else begin
              st_d[idx_q] = dlbu_pkg::DLBU_SHR;
            end
            dat_d[idx_q] = line_m;
          end
          // the line address is aligned; the held request picks the word
          crd_d = line_m[{wsel, 5'h0} +: 32];
        end
      end
      dlbu_pkg::DLBU_WB: begin
        if (axi_awready_i) awv_d = 1'b0;
        if (axi_wready_i) wv_d = 1'b0;
        if ((!awv_q || axi_awready_i) && (!wv_q || axi_wready_i)) begin
          brdy_d = 1'b1;
          fsm_d = dlbu_pkg::DLBU_B;
        end
      end
      dlbu_pkg::DLBU_B: begin
        if (axi_bvalid_i) begin
          brdy_d = 1'b0;
          fsm_d = dlbu_pkg::DLBU_IDLE;
          cack_d = byp_q;
          if (!byp_q) begin
            ben_d[idx_q] = 16'h0;
            st_d[idx_q] = (st_q[idx_q] == dlbu_pkg::DLBU_MOD) ?
                          dlbu_pkg::DLBU_SHR : dlbu_pkg::DLBU_INV;
          end
        end
      end
      default: fsm_d = dlbu_pkg::DLBU_IDLE;
    endcase
    // byte merge of a processor write into the chosen buffer
    if (do_wr) begin
      for (int b = 0; b < 4; b++) begin
        if (cpu_be_i[b]) begin
          dat_d[idx_d][{wsel, 2'(b), 3'h0} +: 8] = cpu_wdata_i[8*b +: 8];
          ben_d[idx_d][{wsel, 2'(b)}] = 1'b1;
        end
      end
      if (st_d[idx_d] == dlbu_pkg::DLBU_WRT && ben_d[idx_d] == 16'hFFFF)
        st_d[idx_d] = dlbu_pkg::DLBU_MOD;
    end
    // recency: used buffer restarts, the others age
    if (evt) begin
      for (int i = 0; i < NBUF; i++) begin
        if (IW'(i) == idx_d) lru_d[i] = '0;
        else if (lru_q[i] != LRU_MAX) lru_d[i] = lru_q[i] + 1'b1;
      end
    end
  end

  // controller flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NBUF; i++) begin
        st_q[i] <= dlbu_pkg::DLBU_INV;
        tag_q[i] <= 28'h0;
        dat_q[i] <= 128'h0;
        ben_q[i] <= 16'h0;
        lru_q[i] <= '0;
      end
      fsm_q <= dlbu_pkg::DLBU_IDLE;
      idx_q <= '0;
      byp_q <= 1'b0;
      cack_q <= 1'b0;
      crd_q <= 32'h0;
      arv_q <= 1'b0;
      ara_q <= 32'h0;
      rrdy_q <= 1'b0;
      awv_q <= 1'b0;
      awa_q <= 32'h0;
      wv_q <= 1'b0;
      wd_q <= 128'h0;
      ws_q <= 16'h0;
      brdy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tag_q <= tag_d;
      dat_q <= dat_d;
      ben_q <= ben_d;
      lru_q <= lru_d;
      fsm_q <= fsm_d;
      idx_q <= idx_d;
      byp_q <= byp_d;
      cack_q <= cack_d;
      crd_q <= crd_d;
      arv_q <= arv_d;
      ara_q <= ara_d;
      rrdy_q <= rrdy_d;
      awv_q <= awv_d;
      awa_q <= awa_d;
      wv_q <= wv_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      brdy_q <= brdy_d;
    end
  end

  // outputs straight from flops
  assign cpu_ack_o = cack_q;
  assign cpu_rdata_o = crd_q;
  assign axi_arvalid_o = arv_q;
  assign axi_araddr_o = ara_q;
  assign axi_rready_o = rrdy_q;
  assign axi_awvalid_o = awv_q;
  assign axi_awaddr_o = awa_q;
  assign axi_wvalid_o = wv_q;
  assign axi_wdata_o = wd_q;
  assign axi_wstrb_o = ws_q;
  assign axi_bready_o = brdy_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence fill_s;
    fsm_q == dlbu_pkg::DLBU_R && axi_rvalid_i && !byp_q;
  endsequence
  sequence fetch_s;
    fsm_q == dlbu_pkg::DLBU_IDLE && cpu_req_i && !cack_q && cpu_fetch_i;
  endsequence

  fill_shared_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fill_s and st_q[idx_q] == dlbu_pkg::DLBU_INV |=> st_q[idx_q] == dlbu_pkg::DLBU_SHR
    && cpu_ack_o) else $error("read fill did not leave a shared line");
  merge_mod_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fill_s and st_q[idx_q] == dlbu_pkg::DLBU_WRT |=> st_q[idx_q] == dlbu_pkg::DLBU_MOD)
    else $error("read of write line did not become modified");
  full_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q[0] == dlbu_pkg::DLBU_WRT |-> ben_q[0] != 16'hFFFF)
    else $error("fully written line still in write state");
  wb_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    axi_wvalid_o && !byp_q |-> axi_wstrb_o == ben_q[idx_q] && axi_wdata_o == dat_q[idx_q])
    else $error("write-back strobes differ from byte enables");
  fetch_bypass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fetch_s |=> byp_q ##0 (axi_arvalid_o || axi_awvalid_o))
    else $error("instruction fetch entered the line buffers");
  alloc_enabled_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q[0] == dlbu_pkg::DLBU_INV ##1 st_q[0] != dlbu_pkg::DLBU_INV |-> $past(en_q[0]))
    else $error("disabled buffer was allocated");
  lru_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cpu_ack_o && !byp_q |-> lru_q[idx_q] == '0)
    else $error("used buffer kept a nonzero age");
  inval_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ipend_q && !fpend_q && fsm_q == dlbu_pkg::DLBU_IDLE && !cpu_req_i && !flush_due
    && !wb_ack_d |=> st_q[0] != dlbu_pkg::DLBU_SHR && !ipend_q)
    else $error("invalidate left a shared line");
  dirty_flush_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fsm_q == dlbu_pkg::DLBU_IDLE && !cpu_req_i && (flush_due || (fpend_q && any_dirty))
    |=> axi_awvalid_o) else $error("dirty buffers above limit not flushed");
  wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("bus ack held longer than one cycle");
endmodule : dlbu_top

// >>> test/dlbu_axi_mem.sv
// behavioural axi memory standing in for the crossbar
`timescale 1ns/100ps
module dlbu_axi_mem (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic axi_arvalid_i,
  input wire logic [31:0] axi_araddr_i,
  output logic axi_arready_o,
  output logic axi_rvalid_o,
  output logic [127:0] axi_rdata_o,
  input wire logic axi_rready_i,
  input wire logic axi_awvalid_i,
  input wire logic [31:0] axi_awaddr_i,
  output logic axi_awready_o,
  input wire logic axi_wvalid_i,
  input wire logic [127:0] axi_wdata_i,
  input wire logic [15:0] axi_wstrb_i,
  output logic axi_wready_o,
  output logic axi_bvalid_o,
  input wire logic axi_bready_i
);
  logic [127:0] mem [logic [27:0]];
  int n_ar = 0;
  int n_aw = 0;
  // untouched lines read back their own word addresses
  function automatic logic [127:0] line(input logic [27:0] a);
    if (mem.exists(a)) return mem[a];
    return {a, 4'hC, a, 4'h8, a, 4'h4, a, 4'h0};
  endfunction : line
  // read channel: stall when slow, one beat, then scrambled data
  initial begin
    logic [27:0] a;
    axi_arready_o = 1'b0;
    axi_rvalid_o = 1'b0;
    axi_rdata_o = '0;
    forever begin
      @(posedge clk_i);
      if (axi_arvalid_i === 1'b1) begin
        if (slow_i) repeat (3) @(posedge clk_i);
        axi_arready_o <= 1'b1;
        @(posedge clk_i);
        a = axi_araddr_i[31:4];
        axi_arready_o <= 1'b0;
        n_ar++;
        axi_rvalid_o <= 1'b1;
        axi_rdata_o <= line(a);
        do @(posedge clk_i); while (axi_rready_i !== 1'b1);
        axi_rvalid_o <= 1'b0;
        axi_rdata_o <= ~line(a);
      end
    end
  end
  // write channel: both halves together, byte strobes honoured
  initial begin
    logic [27:0] a;
    logic [127:0] d;
    axi_awready_o = 1'b0;
    axi_wready_o = 1'b0;
    axi_bvalid_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (axi_awvalid_i === 1'b1 && axi_wvalid_i === 1'b1) begin
        if (slow_i) repeat (2) @(posedge clk_i);
        axi_awready_o <= 1'b1;
        axi_wready_o <= 1'b1;
        @(posedge clk_i);
        a = axi_awaddr_i[31:4];
        d = line(a);
        for (int i = 0; i < 16; i++) begin
          if (axi_wstrb_i[i]) d[8*i +: 8] = axi_wdata_i[8*i +: 8];
        end
        mem[a] = d;
        n_aw++;
        axi_awready_o <= 1'b0;
        axi_wready_o <= 1'b0;
        axi_bvalid_o <= 1'b1;
        do @(posedge clk_i); while (axi_bready_i !== 1'b1);
        axi_bvalid_o <= 1'b0;
      end
    end
  end
endmodule : dlbu_axi_mem

// >>> test/test_data_bus_line_buffer_cache.sv
// self-checking bench for the data line buffer unit
`timescale 1ns/100ps
module test_data_bus_line_buffer_cache;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0, cpu_be = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_q, cpu_addr = 32'h0, cpu_wdata = 32'h0, cpu_rdata;
  logic wb_we = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_ack, slow = 1'b0;
  logic cpu_req = 1'b0, cpu_fetch = 1'b0, cpu_we = 1'b0, cpu_ack;
  logic arv, arr, rv, rr, awv, awr, wv, wr, bv, br;
  logic [31:0] ara, awa;
  logic [127:0] rd, wd;
  logic [15:0] ws;
  int fails = 0;
  int n_checks = 0;
  always #5 clk_i = ~clk_i;
  dlbu_top #(.WIN_HI(32'h1FFFFFFF)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_we_i(wb_we),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
    .cpu_req_i(cpu_req), .cpu_fetch_i(cpu_fetch), .cpu_we_i(cpu_we), .cpu_addr_i(cpu_addr),
    .cpu_be_i(cpu_be), .cpu_wdata_i(cpu_wdata), .cpu_ack_o(cpu_ack), .cpu_rdata_o(cpu_rdata),
    .axi_arvalid_o(arv), .axi_araddr_o(ara), .axi_arready_i(arr), .axi_rvalid_i(rv),
    .axi_rdata_i(rd), .axi_rready_o(rr), .axi_awvalid_o(awv), .axi_awaddr_o(awa),
    .axi_awready_i(awr), .axi_wvalid_o(wv), .axi_wdata_o(wd), .axi_wstrb_o(ws),
    .axi_wready_i(wr), .axi_bvalid_i(bv), .axi_bready_o(br));
  dlbu_axi_mem mem_u (.clk_i(clk_i), .slow_i(slow), .axi_arvalid_i(arv), .axi_araddr_i(ara),
    .axi_arready_o(arr), .axi_rvalid_o(rv), .axi_rdata_o(rd), .axi_rready_i(rr),
    .axi_awvalid_i(awv), .axi_awaddr_i(awa), .axi_awready_o(awr), .axi_wvalid_i(wv),
    .axi_wdata_i(wd), .axi_wstrb_i(ws), .axi_wready_o(wr), .axi_bvalid_o(bv),
    .axi_bready_i(br));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    int i;
    wb_adr <= a;
    wb_we <= w;
    wb_dat <= d;
    wb_sel <= 4'hF;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    i = 0;
    do begin @(posedge clk_i); i++; end while (wb_ack !== 1'b1 && i < 50);
    if (i >= 50) begin fails++; results(); end
    q = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // one processor access, request dropped at the ack edge
  task automatic cpu(input logic f, input logic w, input logic [31:0] a, input logic [3:0] be,
    input logic [31:0] d, output logic [31:0] q);
    int i;
    cpu_fetch <= f;
    cpu_we <= w;
    cpu_addr <= a;
    cpu_be <= be;
    cpu_wdata <= d;
    cpu_req <= 1'b1;
    i = 0;
    do begin @(posedge clk_i); i++; end while (cpu_ack !== 1'b1 && i < 200);
    if (i >= 200) begin fails++; results(); end
    q = cpu_rdata;
    cpu_req <= 1'b0;
    @(posedge clk_i);
  endtask : cpu
  // polls a status bit until it clears
  task automatic poll(input int b, output logic [31:0] s);
    int i;
    i = 0;
    do begin wb(4'h4, 1'b0, 32'h0, s); i++; end while (s[b] !== 1'b0 && i < 100);
    if (i >= 100) begin fails++; results(); end
  endtask : poll
  function automatic logic [31:0] nst(input logic [31:0] s, input logic [1:0] v);
    int n;
    n = 0;
    for (int i = 0; i < 4; i++) if (s[2*i +: 2] === v) n++;
    return 32'(n);
  endfunction : nst
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [31:0] q;
    wb(4'h4, 1'b0, 32'h0, q); chk("status reset", q, 32'h0);
    wb(4'hC, 1'b1, 32'hFFFFFFFF, q);
    wb(4'hC, 1'b0, 32'h0, q); chk("unmapped", q, 32'h0);
    wb(4'h0, 1'b0, 32'h0, q); chk("ctrl reset", q, 32'h0000000F);
    wb(4'h0, 1'b1, 32'h3, q);
    wb(4'h0, 1'b0, 32'h0, q); chk("ctrl", q, 32'h3);
    $display("test regs done");
  endtask : t_regs
  task automatic t_reads();
    logic [31:0] q, s;
    int n1;
    n1 = mem_u.n_ar;
    cpu(1'b0, 1'b0, 32'h10060014, 4'hF, 32'h0, q); chk("miss data", q, 32'h10060014);
    cpu(1'b0, 1'b0, 32'h10060018, 4'hF, 32'h0, q); chk("hit data", q, 32'h10060018);
    chk("fills", 32'(mem_u.n_ar - n1), 32'h1);
    wb(4'h4, 1'b0, 32'h0, s); chk("shared", nst(s, dlbu_pkg::DLBU_SHR), 32'h1);
    chk("disabled idle", s[7:4], 32'h0);
    $display("test reads done");
  endtask : t_reads
  task automatic t_writes();
    logic [31:0] q, s;
    int n0, n1;
    n0 = mem_u.n_aw;
    n1 = mem_u.n_ar;
    slow <= 1'b1;
    cpu(1'b0, 1'b1, 32'h10060104, 4'h3, 32'hAABBCCDD, q);
    cpu(1'b0, 1'b1, 32'h10060108, 4'hF, 32'h11223344, q);
    wb(4'h4, 1'b0, 32'h0, s); chk("write line", nst(s, dlbu_pkg::DLBU_WRT), 32'h1);
    chk("shared kept", nst(s, dlbu_pkg::DLBU_SHR), 32'h1);
    chk("writes held", 32'(mem_u.n_aw - n0), 32'h0);
    chk("no fill yet", 32'(mem_u.n_ar - n1), 32'h0);
    cpu(1'b0, 1'b0, 32'h10060104, 4'hF, 32'h0, q); chk("merged", q, 32'h1006CCDD);
    cpu(1'b0, 1'b0, 32'h10060108, 4'hF, 32'h0, q); chk("kept", q, 32'h11223344);
    wb(4'h4, 1'b0, 32'h0, s); chk("modified", nst(s, dlbu_pkg::DLBU_MOD), 32'h1);
    chk("one fill", 32'(mem_u.n_ar - n1), 32'h1);
    slow <= 1'b0;
    $display("test writes done");
  endtask : t_writes
  task automatic t_evict();
    logic [31:0] q, s;
    logic [127:0] ln;
    int n0, n1;
    n0 = mem_u.n_aw;
    n1 = mem_u.n_ar;
    for (int i = 0; i < 4; i++) begin
      cpu(1'b0, 1'b1, 32'h10060200 + 32'(4*i), 4'hF, 32'hC0DE0000 + 32'(i), q);
    end
    wb(4'h4, 1'b0, 32'h0, s); chk("full line", nst(s, dlbu_pkg::DLBU_MOD), 32'h2);
    chk("no fill", 32'(mem_u.n_ar - n1), 32'h0);
    chk("shared victim", 32'(mem_u.n_aw - n0), 32'h0);
    cpu(1'b0, 1'b0, 32'h10060300, 4'hF, 32'h0, q); chk("new line", q, 32'h10060300);
    chk("write-back", 32'(mem_u.n_aw - n0), 32'h1);
    ln = mem_u.line(28'h1006010);
    chk("old word", ln[63:32], 32'h1006CCDD);
    cpu(1'b0, 1'b1, 32'h10060300, 4'hF, 32'h5A5A5A5A, q);
    wb(4'h4, 1'b0, 32'h0, s); chk("shared hit", nst(s, dlbu_pkg::DLBU_MOD), 32'h2);
    chk("no traffic", 32'(mem_u.n_aw - n0), 32'h1);
    $display("test evict done");
  endtask : t_evict
  task automatic t_flush();
    logic [31:0] q, s;
    logic [127:0] ln;
    cpu(1'b0, 1'b1, 32'h10060400, 4'h1, 32'h000000EE, q);
    wb(4'h0, 1'b1, 32'h103, q);
    poll(16, s);
    chk("dirty left", nst(s, 2'h2) + nst(s, 2'h3), 32'h0);
    chk("kept shared", nst(s, dlbu_pkg::DLBU_SHR), 32'h1);
    wb(4'h0, 1'b1, 32'h203, q);
    poll(17, s);
    chk("empty", s, 32'h0);
    ln = mem_u.line(28'h1006040);
    chk("strobed", ln[31:0], 32'h100604EE);
    ln = mem_u.line(28'h1006030);
    chk("flushed", ln[31:0], 32'h5A5A5A5A);
    ln = mem_u.line(28'h1006020);
    chk("last word", ln[127:96], 32'hC0DE0003);
    $display("test flush done");
  endtask : t_flush
  task automatic t_bypass();
    logic [31:0] q, s;
    logic [127:0] ln;
    cpu(1'b1, 1'b0, 32'h10060500, 4'hF, 32'h0, q); chk("fetch", q, 32'h10060500);
    cpu(1'b0, 1'b0, 32'h20000010, 4'hF, 32'h0, q); chk("outside", q, 32'h20000010);
    cpu(1'b0, 1'b1, 32'h20000020, 4'h2, 32'h0000AB00, q);
    ln = mem_u.line(28'h2000002);
    chk("outside write", ln[31:0], 32'h2000AB20);
    wb(4'h4, 1'b0, 32'h0, s); chk("unbuffered", s, 32'h0);
    $display("test bypass done");
  endtask : t_bypass
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_reads();
    t_writes();
    t_evict();
    t_flush();
    t_bypass();
    results();
  end
endmodule : test_data_bus_line_buffer_cache
